/* rtl/cli_cfg.svh */
`ifndef CLI_CFG_SVH
`define CLI_CFG_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLI_CLK_NS       50
`define CLI_EXEC_NS      26300
`define CLI_EXEC_CYC     ((`CLI_EXEC_NS + `CLI_CLK_NS - 1) / `CLI_CLK_NS)
`define CLI_POR_MS       40
`define CLI_POR_CYC      ((`CLI_POR_MS * 1000000 + `CLI_CLK_NS - 1) / `CLI_CLK_NS)
`define CLI_CLEAR_US     1520
`define CLI_CLEAR_CYC    ((`CLI_CLEAR_US * 1000 + `CLI_CLK_NS - 1) / `CLI_CLK_NS)
`define CLI_CNT_W        20
// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define CLI_SPACE_CODE   8'h20
`define CLI_TRIM_RST     3'h4
`define CLI_CONTRAST_RST 6'h20
`define CLI_GAIN_RST     3'h2
`define CLI_GLYPH_BASE   2'h2
`define CLI_ICON_BASE    4'hC
// ---------------------------------------------------------------
// extended table opcodes (upper nibble)
// ---------------------------------------------------------------
`define CLI_OP_BIAS      4'h1
`define CLI_OP_ICONADR   4'h4
`define CLI_OP_POWER     4'h5
`define CLI_OP_FOLLOW    4'h6
`define CLI_OP_CONTRAST  4'h7
`endif

/* rtl/cli_pkg.sv */
package cli_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_WAIT  = 2'b11,
    ST_CLEAR = 2'b10
  } cli_state_t;

  typedef enum logic [1:0] {
    TGT_DISP  = 2'b00,
    TGT_GLYPH = 2'b01,
    TGT_ICON  = 2'b10
  } cli_tgt_t;
endpackage

/* rtl/cli_mem_if.sv */
`timescale 1ns/100ps
// memory port between engine and storage
interface cli_mem_if (
  input wire logic clk
);
  logic       en;
  logic       we;
  logic       re;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output re, output addr, output wdata, input rdata);
  modport mem  (input clk, input en, input we, input re, input addr, input wdata,
                output rdata);
endinterface

/* rtl/cli_ram.sv */
`timescale 1ns/100ps
// display text, glyph pattern and icon storage, registered read
module cli_ram (
  cli_mem_if.mem m
);
  logic [7:0] store [256];

  // single port, write and registered read
  always_ff @(posedge m.clk) begin
    if (m.en) begin
      if (m.we) begin
        store[m.addr] <= m.wdata;
      end
      if (m.re) begin
        m.rdata <= store[m.addr];
      end
    end
  end
endmodule

/* rtl/cli_engine.sv */
`timescale 1ns/100ps
`include "cli_cfg.svh"
// ---------------------------------------------------------------
// Overview of operation
// R1: busy flag high while executing; refuse instructions
// R2: host waits for busy low first
// R3: status read: busy bit7, address bits 6..0
// R4: address steps by one after data access
// R5: data write stores byte to targeted memory
// R6: address set selects target, loads address
// R7: write steps address per entry direction
// R8: first read after non-address instruction stale
// R9: bias select high quarter, low fifth
// R10: both option inputs high disable bias select
// R11: oscillator trim applied only with clock pin high
// R12: extended 0100 loads icon address 00..0F
// R13: extended 0101 sets icon, booster, contrast high
// R14: booster accepted only with internal follower
// R15: contrast low bits via 0111, follower only
// R16: extended 0110 sets follower enable, gated
// R17: gain ratio accepted only with internal follower
// R18: power-on clears display, busy for 40 ms
// R19: reset loads 8-bit, 1-line, 5x8, normal table, off
// R20: reset sets increment, no shift
// R21: reset loads oscillator trim 100
// R22: reset: icon off, fifth bias, contrast 100000, gain 010
// R23: external reset pin reinitialises as power-on
// R24: table select routes opcodes to extended table
// R25: direction high increments, low decrements
// ---------------------------------------------------------------
module cli_engine #(
  parameter int PorCycles   = `CLI_POR_CYC,
  parameter int ClearCycles = `CLI_CLEAR_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic       cmdValid,
  input  wire logic       cmdRs,
  input  wire logic       cmdRw,
  input  wire logic [7:0] cmdData,
  input  wire logic       externalResetN,
  input  wire logic       clockSourcePin,
  input  wire logic       biasSourceOptA,
  input  wire logic       biasSourceOptB,
  output logic            cmdAccept,
  output logic [7:0]      rdData,
  output logic            rdValid,
  output logic            operationInProgressFlag,
  output logic [6:0]      addressCounter,
  output logic            busWidthSelect,
  output logic            twoLineMode,
  output logic            tallFontSelect,
  output logic            extendedTableSelect,
  output logic            displayOn,
  output logic            pointerOn,
  output logic            pointerFlash,
  output logic            entryIncrement,
  output logic            shiftOnWrite,
  output logic [6:0]      displayShift,
  output logic [2:0]      oscTrimCode,
  output logic [2:0]      oscTrimApplied,
  output logic            biasRatioSelect,
  output logic            biasQuarterActive,
  output logic            iconDisplayOn,
  output logic            boosterOn,
  output logic            followerOn,
  output logic [5:0]      contrastLevel,
  output logic [2:0]      gainRatioCode
);
  import cli_pkg::*;

  typedef struct packed {
    cli_state_t            st;
    logic [`CLI_CNT_W-1:0] cnt;
    logic [6:0]            addressCounter;
    cli_tgt_t              tgt;
    logic [6:0]            clrIdx;
    logic                  capture;
    logic [7:0]            readLatch;
    logic [7:0]            rdData;
    logic                  rdValid;
    logic                  rstS1;
    logic                  rstS2;
    logic                  clkS1;
    logic                  clkS2;
    logic                  optAS1;
    logic                  optAS2;
    logic                  optBS1;
    logic                  optBS2;
    logic                  busWidthSelect;
    logic                  twoLineMode;
    logic                  tallFontSelect;
    logic                  extendedTableSelect;
    logic                  displayOn;
    logic                  pointerOn;
    logic                  pointerFlash;
    logic                  entryIncrement;
    logic                  shiftOnWrite;
    logic [6:0]            displayShift;
    logic [2:0]            oscTrimCode;
    logic [2:0]            oscTrimApplied;
    logic                  biasRatioSelect;
    logic                  biasQuarterActive;
    logic                  iconDisplayOn;
    logic                  boosterOn;
    logic                  followerOn;
    logic [5:0]            contrastLevel;
    logic [2:0]            gainRatioCode;
  } cli_regs_t;

  localparam logic [`CLI_CNT_W-1:0] ExecCnt  = `CLI_CNT_W'(`CLI_EXEC_CYC);
  localparam logic [`CLI_CNT_W-1:0] PorCnt   = `CLI_CNT_W'(PorCycles);
  localparam logic [`CLI_CNT_W-1:0] ClearCnt = `CLI_CNT_W'(ClearCycles);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // power-on defaults, keeps the pin synchronisers
  function automatic cli_regs_t initRegs(input cli_regs_t cur);
    cli_regs_t v;
    v                     = cur;
    v.st                  = ST_CLEAR;                 // R18
    v.cnt                 = PorCnt;                   // R18
    v.clrIdx              = 7'h00;
    v.addressCounter      = 7'h00;
    v.tgt                 = TGT_DISP;
    v.capture             = 1'b0;
    v.rdValid             = 1'b0;
    v.busWidthSelect      = 1'b1;                     // R19
    v.twoLineMode         = 1'b0;                     // R19
    v.tallFontSelect      = 1'b0;                     // R19
    v.extendedTableSelect = 1'b0;                     // R19
    v.displayOn           = 1'b0;                     // R19
    v.pointerOn           = 1'b0;                     // R19
    v.pointerFlash        = 1'b0;                     // R19
    v.entryIncrement      = 1'b1;                     // R20
    v.shiftOnWrite        = 1'b0;                     // R20
    v.displayShift        = 7'h00;
    v.oscTrimCode         = `CLI_TRIM_RST;            // R21
    v.oscTrimApplied      = `CLI_TRIM_RST;
    v.biasRatioSelect     = 1'b0;                     // R22
    v.biasQuarterActive   = 1'b0;
    v.iconDisplayOn       = 1'b0;                     // R22
    v.boosterOn           = 1'b0;                     // R22
    v.followerOn          = 1'b0;                     // R22
    v.contrastLevel       = `CLI_CONTRAST_RST;        // R22
    v.gainRatioCode       = `CLI_GAIN_RST;            // R22
    return v;
  endfunction

  // one step up or down, wrapped to the size of the target memory
  function automatic logic [6:0] addrStep(input cli_tgt_t t, input logic [6:0] a,
                                          input logic inc);
    logic [6:0] s;
    s = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);            // R25
    if (t == TGT_GLYPH) begin
      s = {1'b0, s[5:0]};
    end else if (t == TGT_ICON) begin
      s = {3'b000, s[3:0]};
    end
    return s;
  endfunction

  // physical address of the targeted memory
  function automatic logic [7:0] memMap(input cli_tgt_t t, input logic [6:0] a);
    logic [7:0] m;
    m = {1'b0, a};
    if (t == TGT_GLYPH) begin
      m = {`CLI_GLYPH_BASE, a[5:0]};
    end else if (t == TGT_ICON) begin
      m = {`CLI_ICON_BASE, a[3:0]};
    end
    return m;
  endfunction

  // reset image: the external reset synchroniser starts at the idle level of its pin,
  // so leaving reset does not look like an external reset
  function automatic cli_regs_t rstRegs();
    cli_regs_t v;
    v       = initRegs('0);
    v.rstS1 = 1'b1;
    v.rstS2 = 1'b1;
    return v;
  endfunction

  localparam cli_regs_t RstVal = rstRegs();

  cli_regs_t r;
  cli_regs_t n;
  logic      busy;
  logic      statusRd;
  logic      internalFollower;

  cli_mem_if memBus (.clk(clk));

  cli_ram u_ram (
    .m (memBus.mem)
  );

  assign busy             = (r.st != ST_IDLE);
  assign statusRd         = !cmdRs && cmdRw;
  assign internalFollower = !r.optAS2 && !r.optBS2;
  // with the clock enable high, status reads are always taken, everything else only when idle
  assign cmdAccept        = cmdValid && clkEn && (statusRd || !busy);   // R1
  assign memBus.en        = clkEn;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // sequencing, instruction decode and memory access
  always_comb begin
    n              = r;
    n.rdValid      = 1'b0;
    n.rstS1        = externalResetN;
    n.rstS2        = r.rstS1;
    n.clkS1        = clockSourcePin;
    n.clkS2        = r.clkS1;
    n.optAS1       = biasSourceOptA;
    n.optAS2       = r.optAS1;
    n.optBS1       = biasSourceOptB;
    n.optBS2       = r.optBS1;
    memBus.we      = 1'b0;
    memBus.re      = 1'b0;
    memBus.addr    = memMap(r.tgt, r.addressCounter);
    memBus.wdata   = cmdData;
    case (r.st)
      ST_CLEAR: begin
        // fill the display text region with spaces
        memBus.we    = 1'b1;
        memBus.addr  = {1'b0, r.clrIdx};
        memBus.wdata = `CLI_SPACE_CODE;
        n.clrIdx     = 7'(r.clrIdx + 7'h01);
        if (&r.clrIdx) begin
          n.st = ST_WAIT;
        end
      end
      ST_FETCH: begin
        memBus.re = 1'b1;
        n.capture = 1'b1;
        n.st      = ST_WAIT;
      end
      ST_WAIT: begin
        if (r.capture) begin
          n.readLatch = memBus.rdata;
          n.capture   = 1'b0;
        end
        if (r.cnt <= `CLI_CNT_W'(1)) begin
          n.st = ST_IDLE;
        end else begin
          n.cnt = `CLI_CNT_W'(r.cnt - `CLI_CNT_W'(1));
        end
      end
      default: begin
      end
    endcase
    if (cmdAccept) begin
      if (statusRd) begin
        n.rdData  = {busy, r.addressCounter};                     // R3
        n.rdValid = 1'b1;
      end else begin
        n.st  = ST_WAIT;                                          // R1
        n.cnt = ExecCnt;
        if (cmdRs && cmdRw) begin
          // stale unless an address set or the previous data read prefetched it
          n.rdData         = r.readLatch;                         // R8
          n.rdValid        = 1'b1;
          n.addressCounter = addrStep(r.tgt, r.addressCounter, r.entryIncrement); // R4
          n.st             = ST_FETCH;
        end else if (cmdRs) begin
          memBus.we        = 1'b1;                                // R5
          n.addressCounter = addrStep(r.tgt, r.addressCounter, r.entryIncrement); // R7
          if (r.shiftOnWrite && r.tgt == TGT_DISP) begin
            n.displayShift = r.entryIncrement ? 7'(r.displayShift - 7'h01)
                                              : 7'(r.displayShift + 7'h01);
          end
        end else if (cmdData[7]) begin
          n.tgt            = TGT_DISP;                            // R6
          n.addressCounter = cmdData[6:0];
          n.st             = ST_FETCH;
        end else if (cmdData[6] && !r.extendedTableSelect) begin
          n.tgt            = TGT_GLYPH;                           // R6
          n.addressCounter = {1'b0, cmdData[5:0]};
          n.st             = ST_FETCH;
        end else if (cmdData[6]) begin
          // extended table                                         R24
          case (cmdData[5:4])
            2'b00: begin
              n.tgt            = TGT_ICON;                        // R12
              n.addressCounter = {3'b000, cmdData[3:0]};
              n.st             = ST_FETCH;
            end
            2'b01: begin
              n.iconDisplayOn = cmdData[3];                       // R13
              if (internalFollower) begin
                n.boosterOn          = cmdData[2];                // R14
                n.contrastLevel[5:4] = cmdData[1:0];              // R15
              end
            end
            2'b10: begin
              if (internalFollower) begin
                n.followerOn    = cmdData[3];                     // R16
                n.gainRatioCode = cmdData[2:0];                   // R17
              end
            end
            default: begin
              if (internalFollower) begin
                n.contrastLevel[3:0] = cmdData[3:0];              // R15
              end
            end
          endcase
        end else if (cmdData[5]) begin
          n.busWidthSelect      = cmdData[4];
          n.twoLineMode         = cmdData[3];
          n.tallFontSelect      = cmdData[2];
          n.extendedTableSelect = cmdData[0];                     // R24
        end else if (cmdData[4] && r.extendedTableSelect) begin
          n.biasRatioSelect = cmdData[3];                         // R9
          n.oscTrimCode     = cmdData[2:0];
        end else if (cmdData[4]) begin
          if (cmdData[3]) begin
            n.displayShift = cmdData[2] ? 7'(r.displayShift + 7'h01)
                                        : 7'(r.displayShift - 7'h01);
          end else begin
            n.addressCounter = addrStep(r.tgt, r.addressCounter, cmdData[2]);
          end
        end else if (cmdData[3]) begin
          n.displayOn    = cmdData[2];
          n.pointerOn    = cmdData[1];
          n.pointerFlash = cmdData[0];
        end else if (cmdData[2]) begin
          n.entryIncrement = cmdData[1];                          // R25
          n.shiftOnWrite   = cmdData[0];
        end else if (cmdData[1]) begin
          n.addressCounter = 7'h00;
          n.tgt            = TGT_DISP;
          n.displayShift   = 7'h00;
        end else if (cmdData[0]) begin
          n.addressCounter = 7'h00;
          n.tgt            = TGT_DISP;
          n.displayShift   = 7'h00;
          n.entryIncrement = 1'b1;
          n.clrIdx         = 7'h00;
          n.cnt            = ClearCnt;
          n.st             = ST_CLEAR;
        end
      end
    end
    if (!r.rstS2) begin
      n = initRegs(n);                                            // R23
    end
    // only the second synchroniser stage is read
    n.biasQuarterActive = n.biasRatioSelect && !(r.optAS2 && r.optBS2); // R10
    n.oscTrimApplied    = r.clkS2 ? n.oscTrimCode : `CLI_TRIM_RST;      // R11
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= RstVal;
    end else if (clkEn) begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign rdData                  = r.rdData;
  assign rdValid                 = r.rdValid;
  assign operationInProgressFlag = busy;
  assign addressCounter          = r.addressCounter;
  assign busWidthSelect          = r.busWidthSelect;
  assign twoLineMode             = r.twoLineMode;
  assign tallFontSelect          = r.tallFontSelect;
  assign extendedTableSelect     = r.extendedTableSelect;
  assign displayOn               = r.displayOn;
  assign pointerOn               = r.pointerOn;
  assign pointerFlash            = r.pointerFlash;
  assign entryIncrement          = r.entryIncrement;
  assign shiftOnWrite            = r.shiftOnWrite;
  assign displayShift            = r.displayShift;
  assign oscTrimCode             = r.oscTrimCode;
  assign oscTrimApplied          = r.oscTrimApplied;
  assign biasRatioSelect         = r.biasRatioSelect;
  assign biasQuarterActive       = r.biasQuarterActive;
  assign iconDisplayOn           = r.iconDisplayOn;
  assign boosterOn               = r.boosterOn;
  assign followerOn              = r.followerOn;
  assign contrastLevel           = r.contrastLevel;
  assign gainRatioCode           = r.gainRatioCode;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  busy_hold_a: assert property (cmdAccept && !statusRd |=> busy [*8]) // R1
    else $error("busy not held after instruction");
  status_word_a: assert property (cmdAccept && statusRd |=> // R3
    rdValid && rdData == {$past(busy), $past(r.addressCounter)})
    else $error("status read word wrong");
  addr_step_a: assert property (cmdAccept && cmdRs && r.tgt == TGT_DISP && // R4
    r.entryIncrement |=> r.addressCounter == 7'($past(r.addressCounter) + 7'h01))
    else $error("address did not step up");
  write_store_a: assert property (cmdAccept && cmdRs && !cmdRw |-> // R5
    memBus.we && memBus.wdata == cmdData && memBus.addr == memMap(r.tgt, r.addressCounter))
    else $error("data write not stored");
  addr_set_a: assert property (cmdAccept && !cmdRs && !cmdRw && cmdData[7] // R6
    && r.rstS2 |=> r.tgt == TGT_DISP && r.addressCounter == $past(cmdData[6:0]))
    else $error("display address set wrong");
  bias_gate_a: assert property (r.optAS2 && r.optBS2 && clkEn |=> !biasQuarterActive) // R10
    else $error("bias select active with external resistors");
  osc_trim_a: assert property (!r.clkS2 && clkEn |=> oscTrimApplied == `CLI_TRIM_RST) // R11
    else $error("trim applied with clock pin low");
  booster_gate_a: assert property (cmdAccept && !cmdRs && !cmdRw && // R14
    r.extendedTableSelect && cmdData[7:4] == `CLI_OP_POWER && !internalFollower &&
    r.rstS2 |=> $stable(boosterOn) && $stable(contrastLevel))
    else $error("booster set without internal follower");
  ext_reset_a: assert property (!r.rstS2 && clkEn |=> busy && busWidthSelect && // R23
    entryIncrement && oscTrimCode == `CLI_TRIM_RST && gainRatioCode == `CLI_GAIN_RST)
    else $error("external reset did not reinitialise");
endmodule

/* verif/cli_host_model.sv */
`timescale 1ns/100ps
// host side of the command port: one request at a time, honours the busy flag
module cli_host_model (
  input  wire logic       clk,
  input  wire logic       busy,
  input  wire logic       cmdAccept,
  input  wire logic       rdValid,
  input  wire logic [7:0] rdData,
  output logic            cmdValid,
  output logic            cmdRs,
  output logic            cmdRw,
  output logic [7:0]      cmdData
);
  // idle bus at time zero
  initial begin
    cmdValid = 1'b0;
    cmdRs = 1'b0;
    cmdRw = 1'b0;
    cmdData = 8'h00;
  end

  // wait for idle unless told not to or a status read, present, hold over one edge, release
  task automatic issue(input logic rs, input logic rw, input logic [7:0] d, input bit nw,
                       output logic acc, output logic rv, output logic [7:0] rd);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && !nw && !(rs == 1'b0 && rw == 1'b1) && n < 2000);
    cmdValid = 1'b1;
    cmdRs = rs;
    cmdRw = rw;
    cmdData = d;
    #20;
    acc = cmdAccept;
    @(posedge clk);
    #1;
    rv = rdValid;
    rd = rdData;
    cmdValid = 1'b0;
    cmdData = ~d; // released bus does not keep the last value
  endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic       clk, rstn, clkEn, externalResetN, clockSourcePin, biasSourceOptA, biasSourceOptB;
  logic       cmdValid, cmdRs, cmdRw, cmdAccept, rdValid, operationInProgressFlag, acc, rv;
  logic [7:0] cmdData, rdData, rd, r;
  logic [6:0] addressCounter, displayShift;
  logic [2:0] oscTrimCode, oscTrimApplied, gainRatioCode;
  logic [5:0] contrastLevel;
  logic       busWidthSelect, twoLineMode, tallFontSelect, extendedTableSelect, displayOn;
  logic       pointerOn, pointerFlash, entryIncrement, shiftOnWrite, biasRatioSelect;
  logic       biasQuarterActive, iconDisplayOn, boosterOn, followerOn;
  int         fails, total_checks, mAddr, mInc, eTbl, eTrim, eBias, eIcon, eBoost, eFoll;
  int         eCon, eGain, mem [128];
  int         cycles = 0;

  cli_engine #(.PorCycles(20), .ClearCycles(10)) cli_engine_i (
    .clk, .rstn, .clkEn, .cmdValid, .cmdRs, .cmdRw, .cmdData, .externalResetN, .clockSourcePin,
    .biasSourceOptA, .biasSourceOptB, .cmdAccept, .rdData, .rdValid, .operationInProgressFlag,
    .addressCounter, .busWidthSelect, .twoLineMode, .tallFontSelect, .extendedTableSelect,
    .displayOn, .pointerOn, .pointerFlash, .entryIncrement, .shiftOnWrite, .displayShift,
    .oscTrimCode, .oscTrimApplied, .biasRatioSelect, .biasQuarterActive, .iconDisplayOn,
    .boosterOn, .followerOn, .contrastLevel, .gainRatioCode);
  cli_host_model cli_host_model_i (
    .clk, .busy(operationInProgressFlag), .cmdAccept, .rdValid, .rdData, .cmdValid, .cmdRs,
    .cmdRw, .cmdData);

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // checking helpers and reference model
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic mReset();
    mAddr = 0;
    mInc = 1;
    eTbl = 0;
    eTrim = 4;
    eBias = 0;
    eIcon = 0;
    eBoost = 0;
    eFoll = 0;
    eCon = 32;
    eGain = 2;
    foreach (mem[i]) mem[i] = 8'h20;
  endtask

  task automatic chkCfg();
    int ext;
    ext = biasSourceOptA & biasSourceOptB;
    chk("table", eTbl, extendedTableSelect);
    chk("trim", eTrim, oscTrimCode);
    chk("trimApplied", clockSourcePin ? eTrim : 4, oscTrimApplied);
    chk("bias", eBias, biasRatioSelect);
    chk("biasQuarter", eBias & (ext ^ 1), biasQuarterActive);
    chk("icon", eIcon, iconDisplayOn);
    chk("booster", eBoost, boosterOn);
    chk("follower", eFoll, followerOn);
    chk("contrast", eCon, contrastLevel);
    chk("gain", eGain, gainRatioCode);
    chk("increment", mInc, entryIncrement);
    chk("address", mAddr, addressCounter);
  endtask

  task automatic resetChk();
    logic [8:0] m;
    m = {busWidthSelect, twoLineMode, tallFontSelect, extendedTableSelect, displayOn, pointerOn,
         pointerFlash, entryIncrement, shiftOnWrite};
    chk("busy", 1, operationInProgressFlag);
    chk("modes", 9'h102, m);
    chk("shift", 0, displayShift);
    chkCfg();
  endtask

  // one command; for a status read, d[0] carries the expected busy bit
  task automatic op(input logic rs, input logic rw, input logic [7:0] d, input bit nw = 0);
    logic [7:0] e;
    int in;
    in = !(biasSourceOptA | biasSourceOptB);
    e = rs ? 8'(mem[mAddr]) : {d[0], 7'(mAddr)};
    cli_host_model_i.issue(rs, rw, d, nw, acc, rv, rd);
    chk("accept", !nw, acc);
    if (nw) return;
    if (rw) begin
      chk("rdValid", 1, rv);
      chk(rs ? "data" : "status", e, rd);
    end
    if (rs) begin
      if (!rw) mem[mAddr] = d;
      mAddr = (mAddr + (mInc ? 1 : 127)) % 128;
    end else if (!rw) begin
      if (d[7]) mAddr = d[6:0];
      else if (d[7:5] == 3'b001) eTbl = d[0];
      else if (d[7:2] == 6'b000001) mInc = d[1];
      else if (eTbl != 0) begin
        case (d[7:4])
          4'h1: begin
            eBias = d[3];
            eTrim = d[2:0];
          end
          4'h4: mAddr = d[3:0];
          4'h5: begin
            eIcon = d[3];
            if (in != 0) begin
              eBoost = d[2];
              eCon = d[1:0] * 16 + eCon % 16;
            end
          end
          4'h6: if (in != 0) begin
            eFoll = d[3];
            eGain = d[2:0];
          end
          4'h7: if (in != 0) eCon = eCon / 16 * 16 + d[3:0];
          default: ;
        endcase
      end
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    r = 8'($urandom(32'h4fbad6cb));
    rstn = 1'b0;
    clkEn = 1'b1;
    externalResetN = 1'b1;
    clockSourcePin = 1'b1;
    biasSourceOptA = 1'b0;
    biasSourceOptB = 1'b0;
    fails = 0;
    total_checks = 0;
    mReset();
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    resetChk();
    op(0, 1, 8'h01);
    op(0, 0, 8'h85);
    for (int i = 0; i < 4; i++) op(1, 0, 8'($urandom));
    op(0, 1, 8'h01);
    op(1, 0, 8'hA5, 1);
    op(0, 0, 8'h04);
    repeat (2) op(1, 0, 8'($urandom));
    op(0, 0, 8'h06);
    op(0, 0, 8'h83);
    repeat (6) op(1, 1, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = 8'($urandom) | 8'h80;
      op(0, 0, r);
      op(1, 0, 8'($urandom));
      op(0, 0, r);
      op(1, 1, 8'h00);
    end
    op(0, 0, 8'h31);
    for (int j = 0; j < 4; j++) begin
      biasSourceOptA = j[0];
      biasSourceOptB = j[1];
      clockSourcePin = j[0] ^ j[1];
      repeat (4) @(posedge clk);
      op(0, 0, {4'h1, 4'($urandom)});
      op(0, 0, {4'h5, 4'($urandom)});
      op(0, 0, {4'h6, 4'($urandom)});
      op(0, 0, {4'h7, 4'($urandom)});
      repeat (2) @(posedge clk);
      #1 chkCfg();
    end
    op(0, 0, 8'h4A);
    op(0, 1, 8'h01);
    op(1, 0, 8'h5A);
    op(0, 0, 8'h4A);
    op(1, 1, 8'h00);
    op(0, 0, 8'h30);
    externalResetN = 1'b0;
    repeat (4) @(posedge clk);
    #1 externalResetN = 1'b1;
    mReset();
    repeat (3) @(posedge clk);
    #1 resetChk();
    op(0, 0, 8'h85);
    // a frozen block must still be busy after the execution time, 600 cycles against 526
    clkEn = 1'b0;
    repeat (600) @(posedge clk);
    #1 chk("frozen", 1, operationInProgressFlag);
    clkEn = 1'b1;
    op(1, 1, 8'h00);
    test_done();
  end
endmodule
